// >>> pds_deadband_shutdown.sv
// Dead-band delay and auto-shutdown stage driving four bridge outputs.
// Notes on behaviour
// [R1] Half-bridge delays only inactive-to-active edges.
// [R2] Delay equals count times instruction cycle.
// [R3] Shutdown event forces active pins to shutdown states.
// [R4] Source select decodes comparators and fault combos.
// [R5] Low fault input is a shutdown event.
// [R6] Shutdown forcing is asynchronous, per pin pair.
// [R7] A/C state: low, high, or released.
// [R8] B/D state: low, high, or released.
// [R9] Event sets status bit; status holds shutdown.
// [R10] Restart enable clears status when cause gone.
// [R11] Without restart, software must clear status.
// [R12] Status writes ignored while cause active.
// [R13] Set at period start holds whole period.
// [R14] Comparator sources act as levels.
// [R15] Writing one to status forces shutdown.
// [R16] Polarity chosen per pair by control bits.
// [R17] Software sets polarity before enabling pins.
// [R18] Software waits one full period before pins.
// [R19] Software follows the recommended setup order.
// [R20] Reset makes pins inputs, registers reset.
// [R21] Delay and shutdown registers reset to zero.
// [R22] Half-bridge: A is PWM, B complement.
// [R23] Delay longer than active time keeps inactive.
// [R24] Causes clear when inputs return inactive.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
module pds_deadband_shutdown (
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire pds_pkg::pds_bus_s bus_i,
	output logic [7:0]             rdata_o,
	input  wire logic              pwm_i,
	input  wire logic              period_start_i,
	input  wire pds_pkg::pds_trip_s trip_i,
	output logic [3:0]             bridge_out_o,
	output logic [3:0]             bridge_oe_o
);
	import pds_pkg::*;

	pds_state_s s_r;
	pds_state_s s_nxt;
	logic       cause;
	logic [1:0] pin_ac;
	logic [1:0] pin_bd;

	function automatic logic trip_cause(input logic [2:0] sel,
		input pds_trip_s t);
		trip_cause = (sel[0] & t.cmp1) | (sel[1] & t.cmp2) | // R4 R14 R24
			(sel[2] & ~t.fault_n); // R5
	endfunction

	// Returns {level, drive} for one pair's shutdown state.
	function automatic logic [1:0] sd_pin(input logic [1:0] st);
		if (st[1]) begin
			sd_pin = 2'b00; // R7 R8
		end else begin
			sd_pin = {st[0], 1'b1}; // R7 R8
		end
	endfunction

	assign cause = trip_cause(s_r.shutdown[PDS_POS_SRC +: 3], trip_i);
	assign pin_ac = sd_pin(s_r.shutdown[PDS_POS_AC_STATE +: 2]);
	assign pin_bd = sd_pin(s_r.shutdown[PDS_POS_BD_STATE +: 2]);

	always_comb begin
		logic       wr_sd;
		logic [3:0] act;
		logic [3:0] lvl;
		logic [3:0] drv;
		logic [10:0] limit;
		logic [1:0] sch;
		s_nxt = s_r;
		wr_sd = bus_i.wr && (bus_i.addr == PDS_ADDR_SHUTDOWN);
		act = 4'h0;
		lvl = 4'h0;
		drv = 4'h0;
		limit = 11'(s_r.delay[6:0]) * 11'(PDS_TCY_CYCLES); // R2
		sch = {~pwm_i, pwm_i}; // R22
		s_nxt.rdata = 8'h00;

		if (bus_i.wr) begin
			case (bus_i.addr)
				PDS_ADDR_DELAY: begin
					s_nxt.delay = bus_i.wdata;
				end
				PDS_ADDR_SHUTDOWN: begin
					s_nxt.shutdown[6:0] = bus_i.wdata[6:0];
				end
				PDS_ADDR_CONTROL: begin
					s_nxt.control = {4'h0, bus_i.wdata[3:0]};
				end
				PDS_ADDR_PIN_DIR: begin
					s_nxt.pin_dir = bus_i.wdata[3:0];
				end
				default: begin
				end
			endcase
		end

		// Hardware set wins over any software clear in the same cycle.
		if (cause) begin
			s_nxt.shutdown[PDS_BIT_STATUS] = 1'b1; // R9 R12 R14
		end else if (wr_sd) begin
			s_nxt.shutdown[PDS_BIT_STATUS] =
				bus_i.wdata[PDS_BIT_STATUS]; // R11 R15
		end else if (s_r.delay[PDS_BIT_RESTART]) begin
			s_nxt.shutdown[PDS_BIT_STATUS] = 1'b0; // R10 R24
		end

		if (s_nxt.shutdown[PDS_BIT_STATUS] || s_r.shutdown[PDS_BIT_STATUS]) begin
			s_nxt.run = 1'b0; // R9 R13
		end else if (period_start_i) begin
			s_nxt.run = 1'b1; // R13
		end

		for (int k = 0; k < 2; k++) begin
			if (!sch[k]) begin
				s_nxt.cnt[k] = 11'h000; // R1 R23
				s_nxt.dly[k] = 1'b0; // R1
			end else if (!s_r.dly[k]) begin
				if (s_r.cnt[k] >= limit) begin
					s_nxt.dly[k] = 1'b1; // R1 R2
				end else begin
					s_nxt.cnt[k] = s_r.cnt[k] + 11'h001; // R2
				end
			end
		end

		case (pds_mode_e'(s_r.control[PDS_POS_MODE +: 2]))
			PDS_SINGLE: begin
				act = {3'b000, pwm_i};
			end
			PDS_HALF: begin
				// Next delayed value keeps the falling edge at one cycle.
				act = {2'b00, s_nxt.dly[1], s_nxt.dly[0]}; // R1 R22
			end
			PDS_FULL_FWD: begin
				act = {pwm_i, 2'b00, 1'b1};
			end
			PDS_FULL_REV: begin
				act = {1'b0, 1'b1, pwm_i, 1'b0};
			end
			default: begin
				act = 4'h0;
			end
		endcase

		if (s_r.run && !s_nxt.shutdown[PDS_BIT_STATUS]) begin
			lvl[0] = act[0] ^ s_r.control[PDS_BIT_POL_AC]; // R16
			lvl[2] = act[2] ^ s_r.control[PDS_BIT_POL_AC]; // R16
			lvl[1] = act[1] ^ s_r.control[PDS_BIT_POL_BD]; // R16
			lvl[3] = act[3] ^ s_r.control[PDS_BIT_POL_BD]; // R16
			drv = 4'hf;
		end else begin
			lvl = {pin_bd[1], pin_ac[1], pin_bd[1], pin_ac[1]}; // R3
			drv = {pin_bd[0], pin_ac[0], pin_bd[0], pin_ac[0]}; // R3
		end
		s_nxt.out = lvl;
		s_nxt.oe = drv & ~s_nxt.pin_dir; // R20

		if (bus_i.rd) begin
			case (bus_i.addr)
				PDS_ADDR_DELAY: begin
					s_nxt.rdata = s_r.delay;
				end
				PDS_ADDR_SHUTDOWN: begin
					s_nxt.rdata = s_r.shutdown;
				end
				PDS_ADDR_CONTROL: begin
					s_nxt.rdata = s_r.control;
				end
				PDS_ADDR_PIN_DIR: begin
					s_nxt.rdata = {4'h0, s_r.pin_dir};
				end
				PDS_ADDR_STATUS: begin
					s_nxt.rdata = {2'b00, s_r.run, cause, trip_i.cmp1,
						trip_i.cmp2, trip_i.fault_n, s_r.dly[0]};
				end
				default: begin
					s_nxt.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r.delay    <= PDS_RST_DELAY; // R21
			s_r.shutdown <= PDS_RST_SHUTDOWN; // R21
			s_r.control  <= PDS_RST_CONTROL; // R20
			s_r.pin_dir  <= PDS_RST_PIN_DIR; // R20
			s_r.rdata    <= 8'h00;
			s_r.run      <= 1'b0;
			s_r.cnt      <= '0;
			s_r.dly      <= 2'b00;
			s_r.out      <= 4'h0;
			s_r.oe       <= 4'h0; // R20
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;

	// A live cause overrides the pins without waiting for a clock edge.
	always_comb begin
		if (cause) begin
			bridge_out_o = {pin_bd[1], pin_ac[1], pin_bd[1], pin_ac[1]}; // R6
			bridge_oe_o = {pin_bd[0], pin_ac[0], pin_bd[0], pin_ac[0]} &
				~s_r.pin_dir; // R6
		end else begin
			bridge_out_o = s_r.out;
			bridge_oe_o = s_r.oe;
		end
	end

endmodule

// >>> pds_pkg.sv
// Package with register map, field layout, timing and types of the dead-band and shutdown block.
package pds_pkg;

	localparam logic [7:0] PDS_ADDR_DELAY    = 8'h00;
	localparam logic [7:0] PDS_ADDR_SHUTDOWN = 8'h01;
	localparam logic [7:0] PDS_ADDR_CONTROL  = 8'h02;
	localparam logic [7:0] PDS_ADDR_PIN_DIR  = 8'h03;
	localparam logic [7:0] PDS_ADDR_STATUS   = 8'h04;

	localparam logic [7:0] PDS_RST_DELAY    = 8'h00;
	localparam logic [7:0] PDS_RST_SHUTDOWN = 8'h00;
	localparam logic [7:0] PDS_RST_CONTROL  = 8'h00;
	localparam logic [3:0] PDS_RST_PIN_DIR  = 4'hf;

	localparam int unsigned PDS_BIT_RESTART    = 7;
	localparam int unsigned PDS_BIT_STATUS     = 7;
	localparam int unsigned PDS_POS_SRC        = 4;
	localparam int unsigned PDS_POS_AC_STATE   = 2;
	localparam int unsigned PDS_POS_BD_STATE   = 0;
	localparam int unsigned PDS_POS_MODE       = 2;
	localparam int unsigned PDS_BIT_POL_AC     = 0;
	localparam int unsigned PDS_BIT_POL_BD     = 1;

	localparam int unsigned PDS_CLK_PERIOD_NS = 100;
	localparam int unsigned PDS_TCY_NS        = 100;
	localparam int unsigned PDS_TCY_CYCLES    =
		(PDS_TCY_NS + PDS_CLK_PERIOD_NS - 1) / PDS_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PDS_SINGLE,
		PDS_HALF,
		PDS_FULL_FWD,
		PDS_FULL_REV
	} pds_mode_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pds_bus_s;

	typedef struct packed {
		logic cmp1;
		logic cmp2;
		logic fault_n;
	} pds_trip_s;

	typedef struct packed {
		logic [7:0]       delay;
		logic [7:0]       shutdown;
		logic [7:0]       control;
		logic [3:0]       pin_dir;
		logic [7:0]       rdata;
		logic             run;
		logic [1:0][10:0] cnt;
		logic [1:0]       dly;
		logic [3:0]       out;
		logic [3:0]       oe;
	} pds_state_s;

endpackage

// >>> pds_chk.sv
// Port assertions for the dead-band and shutdown stage.
`timescale 1ns/10ps
module pds_chk
	import pds_pkg::*;
(
	input wire logic       clk_sys_i,
	input wire logic       nrst_i,
	input wire pds_bus_s   bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic       pwm_i,
	input wire logic       period_start_i,
	input wire pds_trip_s  trip_i,
	input wire logic [3:0] bridge_out_o,
	input wire logic [3:0] bridge_oe_o
);
	logic [6:0] sd_r;
	logic       cause;
	// Shadow of the source and state fields, updated by the same writes.
	always_ff @(posedge clk_sys_i or negedge nrst_i)
		if (!nrst_i)
			sd_r <= '0;
		else if (bus_i.wr && bus_i.addr == PDS_ADDR_SHUTDOWN)
			sd_r <= bus_i.wdata[6:0];
	assign cause = sd_r[4] & trip_i.cmp1 | sd_r[5] & trip_i.cmp2
		| sd_r[6] & !trip_i.fault_n;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	a_read_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property (bus_i.rd && bus_i.addr > PDS_ADDR_STATUS
		|=> rdata_o == 8'h00) else $error("unmapped read not zero");
	a_release_pins: assert property ($rose(nrst_i) |-> bridge_oe_o == 4'h0)
		else $error("pins driven after reset");
	a_ac_drive: assert property (cause && !sd_r[3] |->
		bridge_out_o[0] == sd_r[2] && bridge_out_o[2] == sd_r[2])
		else $error("pair a c not in shutdown level");
	a_ac_float: assert property (cause && sd_r[3] |->
		bridge_oe_o[0] == 1'b0 && bridge_oe_o[2] == 1'b0)
		else $error("pair a c not released");
	a_bd_drive: assert property (cause && !sd_r[1] |->
		bridge_out_o[1] == sd_r[0] && bridge_out_o[3] == sd_r[0])
		else $error("pair b d not in shutdown level");
	a_bd_float: assert property (cause && sd_r[1] |->
		bridge_oe_o[1] == 1'b0 && bridge_oe_o[3] == 1'b0)
		else $error("pair b d not released");
	a_hold_period: assert property (cause && !sd_r[3] ##1 !period_start_i [*2]
		|-> sd_r[3] || bridge_out_o[0] == sd_r[2]) else $error("shutdown not held");
endmodule
bind pds_deadband_shutdown pds_chk chk_u (.clk_sys_i(clk_sys_i),
	.nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o), .pwm_i(pwm_i),
	.period_start_i(period_start_i), .trip_i(trip_i),
	.bridge_out_o(bridge_out_o), .bridge_oe_o(bridge_oe_o));

// >>> pds_bridge_model.sv
// Power switch driver inputs seen through the pin pull-downs.
`timescale 1ns/10ps
module pds_bridge_model (
	input  wire logic [3:0] out_i,
	input  wire logic [3:0] oe_i,
	output logic [3:0]      pin_o
);
	// A released pin is pulled low so the switch it feeds stays off.
	assign pin_o = out_i & oe_i;
endmodule

// >>> pwm_deadband_autoshutdown_bench.sv
// Self-checking bench for the dead-band and shutdown stage.
`timescale 1ns/10ps
module pwm_deadband_autoshutdown_bench;
	import pds_pkg::*;
	localparam int DC = 3;
	logic       clk_sys_i = 0, nrst_i = 0, pwm = 0, per = 0;
	pds_bus_s   bus = '0;
	pds_trip_s  trip = 3'b001;
	logic [7:0] rdata, sd;
	logic [3:0] out, oe, pin;
	int         error_cnt = 0, check_count = 0, n, c;
	always #50 clk_sys_i = ~clk_sys_i;
	pds_deadband_shutdown dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.bus_i(bus), .rdata_o(rdata), .pwm_i(pwm), .period_start_i(per),
		.trip_i(trip), .bridge_out_o(out), .bridge_oe_o(oe));
	pds_bridge_model drv_u (.out_i(out), .oe_i(oe), .pin_o(pin));
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_i);
		bus.wr <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys_i);
		bus.rd <= 1'b0;
		#1 chk(nm, rdata, e);
		@(posedge clk_sys_i);
	endtask
	task automatic pulse;
		per <= 1'b1;
		@(posedge clk_sys_i);
		per <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic meas(int i, logic v, int e, string nm);
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1 n++;
		end while (pin[i] !== v && n < 20);
		chk(nm, n[7:0], e[7:0]);
		@(posedge clk_sys_i);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// The whole sequence needs well under a thousand cycles.
	initial begin
		#2000000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		chk("oe_in_reset", {4'h0, oe}, 8'h00);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(PDS_ADDR_DELAY, PDS_RST_DELAY, "delay");
		rd(PDS_ADDR_SHUTDOWN, PDS_RST_SHUTDOWN, "shutdown");
		rd(PDS_ADDR_PIN_DIR, {4'h0, PDS_RST_PIN_DIR}, "pin_dir");
		rd(8'h3c, 8'h00, "unmapped");
		$display("test reset done");
		wr(PDS_ADDR_CONTROL, 8'h00);
		wr(PDS_ADDR_SHUTDOWN, 8'h80);
		pulse();
		wr(PDS_ADDR_PIN_DIR, 8'h00);
		for (int s = 0; s < 8; s++)
			for (int t = 0; t < 3; t++) begin
				sd = {1'b0, s[2:0], 4'b0110};
				wr(PDS_ADDR_SHUTDOWN, sd);
				pulse();
				trip <= (t == 0) ? 3'b101 : (t == 1) ? 3'b011 : 3'b000;
				c = s[t];
				#1 chk("pin_a", {7'h0, pin[0]}, c[7:0]);
				@(posedge clk_sys_i);
				wr(PDS_ADDR_SHUTDOWN, sd);
				rd(PDS_ADDR_SHUTDOWN, {c[0], sd[6:0]}, "status");
				trip <= 3'b001;
			end
		$display("test sources done");
		wr(PDS_ADDR_DELAY, 8'h80);
		wr(PDS_ADDR_SHUTDOWN, 8'h49);
		trip <= 3'b000;
		@(posedge clk_sys_i);
		trip <= 3'b001;
		repeat (3) @(posedge clk_sys_i);
		rd(PDS_ADDR_SHUTDOWN, 8'h49, "restart");
		#1 chk("held_oe", {7'h0, oe[0]}, 8'h00);
		pulse();
		#1 chk("resume_oe", {7'h0, oe[0]}, 8'h01);
		wr(PDS_ADDR_DELAY, 8'h00);
		wr(PDS_ADDR_SHUTDOWN, 8'hc6);
		#1 chk("forced", {7'h0, pin[0]}, 8'h01);
		wr(PDS_ADDR_SHUTDOWN, 8'h46);
		pulse();
		$display("test restart done");
		wr(PDS_ADDR_CONTROL, {4'h0, PDS_HALF, 2'b00});
		wr(PDS_ADDR_DELAY, DC[7:0]);
		pulse();
		pwm <= 1'b1;
		meas(1, 0, 1, "b_fall");
		pwm <= 1'b0;
		meas(0, 0, 1, "a_fall");
		pwm <= 1'b1;
		// Two cycles of the rising delay have already passed in b_fall2.
		meas(1, 0, 1, "b_fall2");
		meas(0, 1, DC * PDS_TCY_CYCLES - 1, "a_rise");
		pwm <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		pwm <= 1'b1;
		repeat (DC - 1) @(posedge clk_sys_i);
		pwm <= 1'b0;
		meas(0, 1, 20, "a_short");
		wr(PDS_ADDR_CONTROL, {4'h0, PDS_HALF, 2'b01});
		repeat (2) @(posedge clk_sys_i);
		#1 chk("pol_a", {7'h0, pin[0]}, 8'h01);
		$display("test dead band done");
		complete_run();
	end
endmodule
